// ---- design/qdsl_top.v ----
// Digital load path of a four-channel voltage DAC: serial receiver, word
// decoder, two-entry word buffer, input registers and DAC registers.
// Assumes every pin input except i_hold_update is asynchronous to i_core_clk and that the serial
// clock is slower than a quarter of the core clock.
// Operation
// - One MSB-first word per frame, 16/14 bits.
// - Sample serial_in on serial clock rising edge.
// - Shift only while chip select is low.
// - Twelve-bit variant keeps last 16 bits.
// - Ten-bit variant keeps last 14 bits.
// - Chip select rise loads addressed channel register.
// - Async zero reset clears input and DAC code registers, overrides loads.
// - Load strobe updates all four channels together.
// - Two MSBs are the shutdown controls.
// - All-off bit shuts down every channel.
// - One-off bit shuts down addressed channel.
// - Channel code is unsigned, 12 or 10 bits.
// - Word layout: off, off, address, code.
// - Address 00..11 selects channel A..D.
// - DAC registers transparent while strobe low.
// - Power-on clears input and DAC registers.
`timescale 1ns/1ps
`default_nettype none
`include "qdsl_map.vh"

module qdsl_top
#(
    parameter TEN_BIT = 0
)
(
    input  wire                                    i_core_clk,
    input  wire                                    i_nrst,
    input  wire                                    i_serial_clk,
    input  wire                                    i_chip_sel_n,
    input  wire                                    i_serial_in,
    input  wire                                    i_load_strobe_n,
    input  wire                                    i_zero_reset_n,
    input  wire                                    i_hold_update,
    output wire                                    o_frame_ready,
    output reg                                     o_frame_drop,
    output reg  [`QDSL_NCHAN*`QDSL_CODE_W-1:0]     o_input_code,
    output reg  [`QDSL_NCHAN*`QDSL_CODE_W-1:0]     o_dac_code,
    output reg  [`QDSL_NCHAN-1:0]                  o_chan_off
);

// ****************************************************************
// Helpers
// ****************************************************************
// Brings a received word into the 16-bit layout, so the decoder below
// needs only one form; the ten-bit code is right-aligned and zero-padded.
function [`QDSL_WORD_W-1:0] norm_word;
    input [`QDSL_WORD_W-1:0] raw;
    begin
        if (TEN_BIT != 0)
        begin
            norm_word = {raw[`QDSL_ALL10_POS], raw[`QDSL_ONE10_POS],
                         raw[`QDSL_AHI10_POS], raw[`QDSL_ALO10_POS],
                         2'h0, raw[`QDSL_CODE10_MSB:0]};
        end
        else
        begin
            norm_word = raw;
        end
    end
endfunction

// A word with neither shutdown bit set is a plain code write.
function plain_word;
    input [`QDSL_WORD_W-1:0] word;
    begin
        plain_word = ~word[`QDSL_ALL_OFF_POS] & ~word[`QDSL_ONE_OFF_POS];
    end
endfunction

// ****************************************************************
// Pin synchronisers
// ****************************************************************
reg  [1:0] sclk_sync;
reg  [1:0] cs_sync;
reg  [1:0] sdi_sync;
reg  [1:0] ld_sync;
reg        sclk_prev;
reg        cs_prev;

always @(posedge i_core_clk or negedge i_nrst)
begin
    if (!i_nrst)
    begin
        sclk_sync <= 2'h0;
        cs_sync   <= 2'h3;
        sdi_sync  <= 2'h0;
        ld_sync   <= 2'h3;
    end
    else
    begin
        sclk_sync <= {sclk_sync[0], i_serial_clk};
        cs_sync   <= {cs_sync[0], i_chip_sel_n};
        sdi_sync  <= {sdi_sync[0], i_serial_in};
        ld_sync   <= {ld_sync[0], i_load_strobe_n};
    end
end

// ****************************************************************
// Edge detection
// ****************************************************************
// The previous-value flops reset to the idle level of each pin, so
// releasing reset never fakes a clock or chip select edge.
always @(posedge i_core_clk or negedge i_nrst)
begin
    if (!i_nrst)
    begin
        sclk_prev <= 1'b0;
        cs_prev   <= 1'b1;
    end
    else
    begin
        sclk_prev <= sclk_sync[1];
        cs_prev   <= cs_sync[1];
    end
end

// All three serial pins pass the same two stages, so data and clock keep
// the alignment the host gave them.
wire sclk_rise = sclk_sync[1] & ~sclk_prev;
wire cs_low    = ~cs_sync[1];
wire cs_rise   = cs_sync[1] & ~cs_prev;
wire ld_low    = ~ld_sync[1];

// ****************************************************************
// Shift register
// ****************************************************************
// Only the most recent bits survive, so surplus leading bits and byte
// padding fall off the top without any bit counting.
reg  [`QDSL_WORD_W-1:0] shift;

always @(posedge i_core_clk or negedge i_nrst)
begin
    if (!i_nrst)
    begin
        shift <= `QDSL_ZERO_WORD;
    end
    else if (sclk_rise && cs_low)
    begin
        shift <= {shift[`QDSL_WORD_W-2:0], sdi_sync[1]};
    end
end

// ****************************************************************
// Two-entry word buffer
// ****************************************************************
reg  [`QDSL_WORD_W-1:0] buf_mem [0:`QDSL_BUF_DEPTH-1];
reg                     wr_ptr;
reg                     rd_ptr;
reg  [`QDSL_CNT_W-1:0]  count;

wire buf_full   = (count == `QDSL_BUF_DEPTH);
wire in_valid   = cs_rise;
wire in_ready   = ~buf_full;
wire out_valid  = (count != 2'h0);
wire out_ready  = ~i_hold_update;
wire push       = in_valid & in_ready;
wire pop        = out_valid & out_ready;

// A frame that ends while both entries are full is lost: the serial link
// cannot push back, so the drop pulse is the host's only sign of it.
assign o_frame_ready = in_ready;

always @(posedge i_core_clk or negedge i_nrst)
begin
    if (!i_nrst)
    begin
        wr_ptr       <= 1'b0;
        rd_ptr       <= 1'b0;
        count        <= 2'h0;
        o_frame_drop <= 1'b0;
        buf_mem[0]   <= `QDSL_ZERO_WORD;
        buf_mem[1]   <= `QDSL_ZERO_WORD;
    end
    else
    begin
        o_frame_drop <= in_valid & ~in_ready;
        if (push)
        begin
            buf_mem[wr_ptr] <= norm_word(shift);
            wr_ptr          <= ~wr_ptr;
        end
        if (pop)
        begin
            rd_ptr <= ~rd_ptr;
        end
        if (push && !pop)
        begin
            count <= count + 2'h1;
        end
        else if (pop && !push)
        begin
            count <= count - 2'h1;
        end
    end
end

// ****************************************************************
// Word decode
// ****************************************************************
wire [`QDSL_WORD_W-1:0] head    = buf_mem[rd_ptr];
wire                    all_off_bit  = head[`QDSL_ALL_OFF_POS];
wire                    one_off_bit  = head[`QDSL_ONE_OFF_POS];
wire                    chan_addr_hi = head[`QDSL_ADDR_HI_POS];
wire                    chan_addr_lo = head[`QDSL_ADDR_LO_POS];
wire [`QDSL_ADDR_W-1:0] addr    = {chan_addr_hi, chan_addr_lo};
wire [`QDSL_CODE_W-1:0] code    = head[`QDSL_CODE_MSB:0];

// ****************************************************************
// Zero reset retiming
// ****************************************************************
// The zero reset pin clears the code registers the moment it falls
// and wins over every load. Its release is retimed through two
// flip-flops, so no code register leaves the clear on a metastable
// edge; the cost is two core cycles before the first load can land.
reg  [1:0] zr_sync;
wire       zr_async_n = i_nrst & i_zero_reset_n;

always @(posedge i_core_clk or negedge zr_async_n)
begin
    if (!zr_async_n)
    begin
        zr_sync <= 2'h0;
    end
    else
    begin
        zr_sync <= {zr_sync[0], 1'b1};
    end
end

wire clr_n = zr_sync[1];

// ****************************************************************
// Input registers, shutdown state and DAC registers
// ****************************************************************
genvar ch;
generate
    for (ch = 0; ch < `QDSL_NCHAN; ch = ch + 1)
    begin : g_chan
        wire hit = (addr == ch);

        always @(posedge i_core_clk or negedge clr_n)
        begin
            if (!clr_n)
            begin
                o_input_code[ch*`QDSL_CODE_W +: `QDSL_CODE_W] <= `QDSL_ZERO_CODE;
            end
            else if (pop && plain_word(head) && hit)
            begin
                o_input_code[ch*`QDSL_CODE_W +: `QDSL_CODE_W] <= code;
            end
        end

        // Shutdown state is not a code register, so the zero reset leaves it;
        // only the core reset or a plain write to its channel clears it.
        always @(posedge i_core_clk or negedge i_nrst)
        begin
            if (!i_nrst)
            begin
                o_chan_off[ch] <= 1'b0;
            end
            else if (pop)
            begin
                if (all_off_bit)
                begin
                    o_chan_off[ch] <= 1'b1;
                end
                else if (one_off_bit && hit)
                begin
                    o_chan_off[ch] <= 1'b1;
                end
                else if (plain_word(head) && hit)
                begin
                    o_chan_off[ch] <= 1'b0;
                end
            end
        end

        // While the strobe is low the DAC register follows its input
        // register; the last value taken before the rise is held.
        always @(posedge i_core_clk or negedge clr_n)
        begin
            if (!clr_n)
            begin
                o_dac_code[ch*`QDSL_CODE_W +: `QDSL_CODE_W] <= `QDSL_ZERO_CODE;
            end
            else if (ld_low)
            begin
                o_dac_code[ch*`QDSL_CODE_W +: `QDSL_CODE_W] <=
                    o_input_code[ch*`QDSL_CODE_W +: `QDSL_CODE_W];
            end
        end
    end
endgenerate

endmodule

`default_nettype wire

// ---- design/qdsl_map.vh ----
// Constants for the quad DAC serial load block.
// Assumes inclusion by the design files only; holds definitions and nothing else.
`ifndef QDSL_MAP_VH
`define QDSL_MAP_VH

// ****************************************************************
// Word formats
// ****************************************************************
`define QDSL_WORD_W      16
`define QDSL_WORD10_W    14
`define QDSL_CODE_W      12
`define QDSL_CODE10_W    10
`define QDSL_NCHAN       4
`define QDSL_ADDR_W      2

// Positions in the normalised 16-bit layout.
`define QDSL_ALL_OFF_POS 15
`define QDSL_ONE_OFF_POS 14
`define QDSL_ADDR_HI_POS 13
`define QDSL_ADDR_LO_POS 12
`define QDSL_CODE_MSB    11

// Positions in the 14-bit layout of the ten-bit variant.
`define QDSL_ALL10_POS   13
`define QDSL_ONE10_POS   12
`define QDSL_AHI10_POS   11
`define QDSL_ALO10_POS   10
`define QDSL_CODE10_MSB  9

// ****************************************************************
// Reset values and buffer shape
// ****************************************************************
`define QDSL_ZERO_CODE   12'h000
`define QDSL_ZERO_WORD   16'h0000
`define QDSL_OFF_RESET   4'h0
`define QDSL_BUF_DEPTH   2
`define QDSL_CNT_W       2

`endif

// ---- verification/qdsl_top_sva.sv ----
// Port assertions for the quad DAC serial load block.
// Assumes the core clock and the async active-low reset of qdsl_top.
`timescale 1ns/1ps
`default_nettype none
module qdsl_chk #(parameter TEN_BIT = 0) (
    input wire logic        i_core_clk,
    input wire logic        i_nrst,
    input wire logic        i_serial_clk,
    input wire logic        i_chip_sel_n,
    input wire logic        i_serial_in,
    input wire logic        i_load_strobe_n,
    input wire logic        i_zero_reset_n,
    input wire logic        i_hold_update,
    input wire logic        o_frame_ready,
    input wire logic        o_frame_drop,
    input wire logic [47:0] o_input_code,
    input wire logic [47:0] o_dac_code,
    input wire logic [3:0]  o_chan_off
);
    // ********
    // Properties
    // ********
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    function automatic int moved(input logic [47:0] a, input logic [47:0] b);
        moved = 0;
        for (int k = 0; k < 4; k++)
            moved += int'(a[k*12+:12] != b[k*12+:12]);
    endfunction
    chk_zero_clears: assert property (!i_zero_reset_n |=> o_input_code == 48'h0 && o_dac_code == 48'h0)
        else $error("zero reset left a code");
    chk_dac_holds: assert property ((i_load_strobe_n && i_zero_reset_n)[*5] |-> $stable(o_dac_code))
        else $error("dac code moved while strobe high");
    chk_dac_follows: assert property ((!i_load_strobe_n && i_zero_reset_n)[*5] |-> o_dac_code == $past(o_input_code))
        else $error("dac code not following input code");
    chk_select_quiet: assert property ((i_chip_sel_n && !i_hold_update && i_zero_reset_n)[*8] |-> $stable({o_input_code, o_chan_off}))
        else $error("registers moved without a frame");
    chk_one_lane: assert property ($changed(o_input_code) && i_zero_reset_n && $past(i_zero_reset_n) |-> moved(o_input_code, $past(o_input_code)) == 1)
        else $error("more than one lane written");
    chk_drop_full: assert property (o_frame_drop |-> !$past(o_frame_ready))
        else $error("frame dropped with room left");
    chk_drop_pulse: assert property (o_frame_drop |=> !o_frame_drop)
        else $error("drop flag longer than one cycle");
    chk_reset_clean: assert property ($rose(i_nrst) |-> o_input_code == 48'h0 && o_dac_code == 48'h0 && o_chan_off == 4'h0)
        else $error("outputs not clear after reset");
    cover property (o_frame_drop);
    cover property (o_chan_off == 4'hF);
    cover property ($changed(o_dac_code));
endmodule
bind qdsl_top qdsl_chk #(.TEN_BIT(TEN_BIT)) u_chk (.*);
`default_nettype wire

// ---- verification/qdsl_host.sv ----
// Host serial port model: drives serial clock, chip select and data.
// Assumes the bench core clock; the serial clock idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module qdsl_host (
    input  wire logic i_core_clk,
    output var  logic o_serial_clk,
    output var  logic o_chip_sel_n,
    output var  logic o_serial_in
);
    // ********
    // Frame driver
    // ********
    initial
    begin
        o_serial_clk = 1'b0;
        o_chip_sel_n = 1'b1;
        o_serial_in  = 1'b0;
    end
    task automatic half();
        repeat (10) @(negedge i_core_clk);
    endtask
    task automatic send(input logic [19:0] w, input int n, input logic sel_hi);
        o_chip_sel_n <= sel_hi;
        half();
        for (int k = n - 1; k >= 0; k--)
        begin
            o_serial_in  <= w[k];
            half();
            o_serial_clk <= 1'b1;
            half();
            o_serial_clk <= 1'b0;
        end
        // A released data line must not keep showing the last bit.
        o_serial_in  <= ~o_serial_in;
        half();
        o_chip_sel_n <= 1'b1;
        half();
    endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the quad DAC serial load block.
// Assumes the host model qdsl_host and the checker bound to qdsl_top.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic             i_core_clk;
    logic             i_nrst;
    logic             i_load_strobe_n;
    logic             i_zero_reset_n;
    logic             i_hold_update;
    wire logic        i_serial_clk;
    wire logic        i_chip_sel_n;
    wire logic        i_serial_in;
    wire logic        o_frame_ready;
    wire logic        o_frame_drop;
    wire logic [47:0] o_input_code;
    wire logic [47:0] o_dac_code;
    wire logic [3:0]  o_chan_off;
    wire logic        ten_frame_ready;
    wire logic        ten_frame_drop;
    wire logic [47:0] ten_input_code;
    wire logic [47:0] ten_dac_code;
    wire logic [3:0]  ten_chan_off;
    logic [47:0]      exp_code;
    int               num_errors = 0;
    int               checks_done = 0;
    int               drops = 0;
    // ********
    // Harness and scenarios
    // ********
    qdsl_top u_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_serial_clk(i_serial_clk),
        .i_chip_sel_n(i_chip_sel_n), .i_serial_in(i_serial_in), .i_load_strobe_n(i_load_strobe_n),
        .i_zero_reset_n(i_zero_reset_n), .i_hold_update(i_hold_update), .o_frame_ready(o_frame_ready),
        .o_frame_drop(o_frame_drop), .o_input_code(o_input_code), .o_dac_code(o_dac_code),
        .o_chan_off(o_chan_off));
    // The ten-bit variant listens to the same pins; only its own scenario and the bound checker judge it.
    qdsl_top #(.TEN_BIT(1)) u_dut_ten (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_serial_clk(i_serial_clk),
        .i_chip_sel_n(i_chip_sel_n), .i_serial_in(i_serial_in), .i_load_strobe_n(i_load_strobe_n),
        .i_zero_reset_n(i_zero_reset_n), .i_hold_update(i_hold_update), .o_frame_ready(ten_frame_ready),
        .o_frame_drop(ten_frame_drop), .o_input_code(ten_input_code), .o_dac_code(ten_dac_code),
        .o_chan_off(ten_chan_off));
    qdsl_host u_host (.i_core_clk(i_core_clk), .o_serial_clk(i_serial_clk), .o_chip_sel_n(i_chip_sel_n),
        .o_serial_in(i_serial_in));
    initial
    begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    always @(negedge i_core_clk)
        if (o_frame_drop === 1'b1)
            drops++;
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wait8();
        repeat (8) @(negedge i_core_clk);
    endtask
    // Four junk bits lead every word, so only the last sixteen may count.
    task automatic put(input logic [1:0] mode, input logic [1:0] ch, input logic [11:0] code);
        u_host.send({4'h9, mode, ch, code}, 20, 1'b0);
        wait8();
    endtask
    task automatic t_lanes();
        for (int c = 0; c < 4; c++)
        begin
            put(2'b00, c[1:0], 12'hFFF - 12'h111 * c[11:0]);
            exp_code[c*12+:12] = 12'hFFF - 12'h111 * c[11:0];
        end
        chk("input_code", exp_code, o_input_code);
        chk("dac_held", 48'h0, o_dac_code);
        i_load_strobe_n <= 1'b0;
        wait8();
        chk("dac_follow", exp_code, o_dac_code);
        i_load_strobe_n <= 1'b1;
        wait8();
        u_host.send(20'h00123, 16, 1'b0);
        u_host.send(20'h03456, 16, 1'b1);
        // A short frame tops up the shift register, so stray shifts above would surface here.
        u_host.send(20'h00045, 8, 1'b0);
        exp_code[11:0] = 12'h123;
        exp_code[35:24] = 12'h345;
        chk("byte_pair", exp_code, o_input_code);
        chk("dac_latched", {36'h0, 12'hFFF}, {36'h0, o_dac_code[11:0]});
    endtask
    task automatic t_off();
        put(2'b01, 2'd2, 12'h000);
        chk("one_off", 48'h4, {44'h0, o_chan_off});
        chk("code_kept", exp_code, o_input_code);
        put(2'b00, 2'd2, 12'h777);
        exp_code[35:24] = 12'h777;
        chk("woken", exp_code, o_input_code);
        chk("woken_off", 48'h0, {44'h0, o_chan_off});
        put(2'b11, 2'd0, 12'h000);
        chk("all_off", 48'hF, {44'h0, o_chan_off});
        chk("all_off_code", exp_code, o_input_code);
    endtask
    task automatic t_zero();
        i_zero_reset_n <= 1'b0;
        wait8();
        chk("zeroed", 48'h0, o_input_code | o_dac_code);
        chk("off_kept", 48'hF, {44'h0, o_chan_off});
        i_zero_reset_n <= 1'b1;
        exp_code = 48'h0;
    endtask
    task automatic t_buffer();
        i_hold_update <= 1'b1;
        put(2'b00, 2'd0, 12'hAAA);
        put(2'b00, 2'd1, 12'h555);
        chk("ready_full", 48'h0, {47'h0, o_frame_ready});
        put(2'b00, 2'd2, 12'h0F0);
        chk("drops", 48'h1, 48'(drops));
        i_hold_update <= 1'b0;
        wait8();
        exp_code[23:0] = 24'h555AAA;
        chk("drained", exp_code, o_input_code);
    endtask
    // Two padding bits lead each fourteen-bit word, as a byte-wide host sends it.
    task automatic t_ten();
        u_host.send({4'h0, 2'b10, 2'b00, 2'b11, 10'h2A5}, 16, 1'b0);
        chk("ten_code", {12'h2A5, 36'h0}, ten_input_code);
        u_host.send({4'h0, 2'b11, 2'b01, 2'b01, 10'h000}, 16, 1'b0);
        chk("ten_one_off", 48'h2, {44'h0, ten_chan_off});
        chk("ten_kept", {12'h2A5, 36'h0}, ten_input_code);
    endtask
    initial
    begin
        i_nrst = 1'b0;
        i_load_strobe_n = 1'b1;
        i_zero_reset_n = 1'b1;
        i_hold_update = 1'b0;
        exp_code = 48'h0;
        repeat (3) @(negedge i_core_clk);
        i_nrst <= 1'b1;
        wait8();
        chk("reset_state", 48'h0, o_input_code | o_dac_code);
        chk("reset_ready", 48'h1, {43'h0, o_chan_off, o_frame_ready});
        t_lanes();
        t_off();
        t_zero();
        t_buffer();
        i_nrst <= 1'b0;
        wait8();
        i_nrst <= 1'b1;
        wait8();
        chk("rereset", 48'h0, o_input_code | o_dac_code);
        chk("rereset_off", 48'h0, {44'h0, o_chan_off});
        t_ten();
        summarize();
    end
    initial
    begin
        #400000;
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
